// ---- can_mbox_cfg.svh ----
// Register offsets, field positions and reset values of the mailbox and queue status logic.
`ifndef CAN_MBOX_CFG_SVH
`define CAN_MBOX_CFG_SVH

`define TX_STATUS_OFS 8'h08
`define RXQ0_STATUS_OFS 8'h0C
`define RXQ1_STATUS_OFS 8'h10

`define TX_DONE_BIT 0
`define TX_OK_BIT 1
`define TX_ARB_BIT 2
`define TX_ERR_BIT 3
`define TX_CANCEL_BIT 7
`define TX_STRIDE 8
`define TX_EMPTY_BIT 26

`define RXQ_COUNT_LSB 0
`define RXQ_FULL_BIT 3
`define RXQ_OVR_BIT 4
`define RXQ_REL_BIT 5

`define EMPTY_RESET 3'h7
`define RXQ_DEPTH_DEFAULT 2'h3
`define WORD_ZERO 32'h0000_0000

`endif

// ---- can_mbox_pkg.sv ----
// Types shared by the mailbox and receive queue status logic.
package can_mbox_pkg;

    typedef logic [1:0] rxq_count_t;

    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_TX,
        SEL_RXQ0,
        SEL_RXQ1
    } reg_sel_t;

endpackage

// ---- can_mailbox_fifo_status.sv ----
// Transmit mailbox status and receive queue status registers of the CAN controller.
//
// Overview of operation
// - Arbitration loss sets flag; write-one or start clears.
// - Success flag follows outcome; write-one clears it.
// - Done flag sets on finish; new request clears.
// - Clearing done also clears success, arbitration, error.
// - Error flag shows a transmission error occurred.
// - Cancel write-one aborts pending transmission only.
// - Mailbox one arbitration flag shows arbitration loss.
// - Mailbox one done flag, write-one clears.
// - Status bits six to four reserved, zero.
// - Queue zero release drops oldest, self clears.
// - Queue zero release ignored while queue empty.
// - Queue zero overrun on arrival while full.
// - Queue zero full flag at three messages.
// - Queue zero count increments on accepted message.
// - Queue zero count decrements on each release.
// - Queue one release drops oldest, self clears.
// - Queue one overrun on arrival while full.
// - Queue one full flag at three messages.
// - Queue one count tracks accepts and releases.
// - Empty flags show idle mailboxes, set after reset.
`timescale 1ns/1ps
`include "can_mbox_cfg.svh"

module can_mailbox_fifo_status
    import can_mbox_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter rxq_count_t RXQ_DEPTH = `RXQ_DEPTH_DEFAULT
)
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic [2:0] i_tx_request,
    input wire logic [2:0] i_tx_start,
    input wire logic [2:0] i_tx_success,
    input wire logic [2:0] i_tx_arb_lost,
    input wire logic [2:0] i_tx_error,
    input wire logic [2:0] i_tx_abort_done,
    output logic [2:0] o_mbox_empty,
    output logic [1:0] o_mbox_cancel,
    input wire logic [1:0] i_rxq_accept,
    output logic [1:0] o_rxq_release,
    output logic [1:0] o_rxq0_count,
    output logic [1:0] o_rxq1_count
);

    logic [2:0] mbox_empty;
    logic [1:0] mbox0_tx_done;
    logic [1:0] mbox_tx_ok;
    logic [1:0] mbox_arb_lost;
    logic [1:0] mbox_tx_err;
    logic [1:0] mbox_cancel;
    rxq_count_t rxq_count [2];
    rxq_count_t next_rxq_count [2];
    logic [1:0] rxq_full;
    logic [1:0] rxq_overrun;
    logic [1:0] rxq_release;
    logic [31:0] rdata;
    reg_sel_t wr_sel;
    reg_sel_t rd_sel;
    logic [31:0] tx_w1;
    logic [31:0] rxq_w1 [2];
    logic [31:0] tx_word;
    logic [31:0] rxq_word [2];

    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
        if (addr == ADDR_W'(`TX_STATUS_OFS))
        begin
            return SEL_TX;
        end
        else if (addr == ADDR_W'(`RXQ0_STATUS_OFS))
        begin
            return SEL_RXQ0;
        end
        else if (addr == ADDR_W'(`RXQ1_STATUS_OFS))
        begin
            return SEL_RXQ1;
        end
        else
        begin
            return SEL_NONE;
        end
    endfunction

    // Count step shared by both queues; a message that arrives while the queue
    // is full is dropped, so the count never passes the depth.
    function automatic rxq_count_t count_step(input rxq_count_t cnt,
                                              input logic accept,
                                              input logic release_now);
        logic inc;
        inc = accept && (cnt != RXQ_DEPTH);
        if (inc && !release_now)
        begin
            return rxq_count_t'(cnt + 2'h1);
        end
        else if (!inc && release_now)
        begin
            return rxq_count_t'(cnt - 2'h1);
        end
        else
        begin
            return cnt;
        end
    endfunction

    // A hardware set wins over a clear in the same cycle, so an event that races a
    // software write is never lost.
    function automatic logic sticky(input logic cur, input logic hit, input logic clr);
        return hit || (cur && !clr);
    endfunction

    always_comb
    begin
        wr_sel = i_wr ? decode(i_addr) : SEL_NONE;
        rd_sel = i_rd ? decode(i_addr) : SEL_NONE;
    end

    // Only ones in the write data act; zeros leave every bit alone.
    always_comb
    begin
        tx_w1 = (wr_sel == SEL_TX) ? i_wdata : `WORD_ZERO;
        rxq_w1[0] = (wr_sel == SEL_RXQ0) ? i_wdata : `WORD_ZERO;
        rxq_w1[1] = (wr_sel == SEL_RXQ1) ? i_wdata : `WORD_ZERO;
    end

    always_comb
    begin
        for (int q = 0; q < 2; q++)
        begin
            next_rxq_count[q] = count_step(rxq_count[q], i_rxq_accept[q], rxq_release[q]);
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            mbox_empty <= `EMPTY_RESET;
        end
        else
        begin
            for (int m = 0; m < 3; m++)
            begin
                if (i_tx_request[m])
                begin
                    mbox_empty[m] <= 1'b0;
                end
                else if (i_tx_success[m] || i_tx_abort_done[m])
                begin
                    mbox_empty[m] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            mbox0_tx_done <= 2'h0;
        end
        else
        begin
            for (int m = 0; m < 2; m++)
            begin
                mbox0_tx_done[m] <= sticky(mbox0_tx_done[m],
                                           i_tx_success[m] || i_tx_abort_done[m],
                                           tx_w1[m*`TX_STRIDE+`TX_DONE_BIT] || i_tx_request[m]);
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            mbox_tx_ok <= 2'h0;
        end
        else
        begin
            for (int m = 0; m < 2; m++)
            begin
                mbox_tx_ok[m] <= sticky(mbox_tx_ok[m], i_tx_success[m],
                                        i_tx_arb_lost[m] || i_tx_error[m] || i_tx_abort_done[m] ||
                                        tx_w1[m*`TX_STRIDE+`TX_OK_BIT] ||
                                        tx_w1[m*`TX_STRIDE+`TX_DONE_BIT]);
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            mbox_arb_lost <= 2'h0;
        end
        else
        begin
            for (int m = 0; m < 2; m++)
            begin
                mbox_arb_lost[m] <= sticky(mbox_arb_lost[m], i_tx_arb_lost[m],
                                           tx_w1[m*`TX_STRIDE+`TX_ARB_BIT] || i_tx_start[m] ||
                                           tx_w1[m*`TX_STRIDE+`TX_DONE_BIT]);
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            mbox_tx_err <= 2'h0;
        end
        else
        begin
            for (int m = 0; m < 2; m++)
            begin
                mbox_tx_err[m] <= sticky(mbox_tx_err[m], i_tx_error[m],
                                         tx_w1[m*`TX_STRIDE+`TX_ERR_BIT] || i_tx_start[m] ||
                                         tx_w1[m*`TX_STRIDE+`TX_DONE_BIT]);
            end
        end
    end

    // The cancel request drops as soon as the mailbox is freed, because a
    // request left standing would abort the next message put into it.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            mbox_cancel <= 2'h0;
        end
        else
        begin
            for (int m = 0; m < 2; m++)
            begin
                if (i_tx_success[m] || i_tx_abort_done[m] || mbox_empty[m])
                begin
                    mbox_cancel[m] <= 1'b0;
                end
                else if (tx_w1[m*`TX_STRIDE+`TX_CANCEL_BIT])
                begin
                    mbox_cancel[m] <= 1'b1;
                end
            end
        end
    end

    // A release lasts one cycle: the count drops on the edge that clears it.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            rxq_release <= 2'h0;
        end
        else
        begin
            for (int q = 0; q < 2; q++)
            begin
                if (rxq_release[q])
                begin
                    rxq_release[q] <= 1'b0;
                end
                else if (rxq_w1[q][`RXQ_REL_BIT] && (rxq_count[q] != 2'h0))
                begin
                    rxq_release[q] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            rxq_count[0] <= 2'h0;
            rxq_count[1] <= 2'h0;
        end
        else
        begin
            rxq_count[0] <= next_rxq_count[0];
            rxq_count[1] <= next_rxq_count[1];
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            rxq_full <= 2'h0;
        end
        else
        begin
            for (int q = 0; q < 2; q++)
            begin
                rxq_full[q] <= sticky(rxq_full[q], next_rxq_count[q] == RXQ_DEPTH,
                                      rxq_w1[q][`RXQ_FULL_BIT]);
            end
        end
    end

    // A release in the same cycle as a full-queue arrival does not make room
    // in time, so that message is still counted as lost.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            rxq_overrun <= 2'h0;
        end
        else
        begin
            for (int q = 0; q < 2; q++)
            begin
                rxq_overrun[q] <= sticky(rxq_overrun[q],
                                         i_rxq_accept[q] && (rxq_count[q] == RXQ_DEPTH),
                                         rxq_w1[q][`RXQ_OVR_BIT]);
            end
        end
    end

    always_comb
    begin
        tx_word = `WORD_ZERO;
        for (int m = 0; m < 2; m++)
        begin
            tx_word[m*`TX_STRIDE+`TX_DONE_BIT] = mbox0_tx_done[m];
            tx_word[m*`TX_STRIDE+`TX_OK_BIT] = mbox_tx_ok[m];
            tx_word[m*`TX_STRIDE+`TX_ARB_BIT] = mbox_arb_lost[m];
            tx_word[m*`TX_STRIDE+`TX_ERR_BIT] = mbox_tx_err[m];
            tx_word[m*`TX_STRIDE+`TX_CANCEL_BIT] = mbox_cancel[m];
        end
        for (int m = 0; m < 3; m++)
        begin
            tx_word[`TX_EMPTY_BIT+m] = mbox_empty[m];
        end
        for (int q = 0; q < 2; q++)
        begin
            rxq_word[q] = `WORD_ZERO;
            rxq_word[q][`RXQ_COUNT_LSB+:2] = rxq_count[q];
            rxq_word[q][`RXQ_FULL_BIT] = rxq_full[q];
            rxq_word[q][`RXQ_OVR_BIT] = rxq_overrun[q];
            rxq_word[q][`RXQ_REL_BIT] = rxq_release[q];
        end
    end

    // Read data stands for the single cycle after the strobe and is zero
    // otherwise, including for unmapped addresses.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            rdata <= `WORD_ZERO;
        end
        else if (rd_sel == SEL_TX)
        begin
            rdata <= tx_word;
        end
        else if (rd_sel == SEL_RXQ0)
        begin
            rdata <= rxq_word[0];
        end
        else if (rd_sel == SEL_RXQ1)
        begin
            rdata <= rxq_word[1];
        end
        else
        begin
            rdata <= `WORD_ZERO;
        end
    end

    always_comb
    begin
        o_rdata = rdata;
        o_mbox_empty = mbox_empty;
        o_mbox_cancel = mbox_cancel;
        o_rxq_release = rxq_release;
        o_rxq0_count = rxq_count[0];
        o_rxq1_count = rxq_count[1];
    end

endmodule

// ---- can_tx_core_model.sv ----
// Behavioural transmit engine that answers the status block's mailbox 0 cancel output.
`timescale 1ns/1ps
module can_tx_core_model (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [2:0] i_op,
    input wire logic [1:0] i_mb,
    input wire logic [3:0] i_lag,
    input wire logic [1:0] i_cancel,
    output logic [2:0] o_req,
    output logic [2:0] o_start,
    output logic [2:0] o_ok,
    output logic [2:0] o_arb,
    output logic [2:0] o_err,
    output logic [2:0] o_abort
);
    // The abort answers after a programmable lag, so slow engines are covered too.
    logic [3:0] lag_cnt;
    always_ff @(posedge i_core_clk)
    begin
        o_req <= {2'h0, i_op == 3'h1} << i_mb;
        o_start <= {2'h0, i_op == 3'h2} << i_mb;
        o_ok <= {2'h0, i_op == 3'h3} << i_mb;
        o_arb <= {2'h0, i_op == 3'h4} << i_mb;
        o_err <= {2'h0, i_op == 3'h5} << i_mb;
        o_abort <= 3'h0;
        lag_cnt <= 4'h0;
        if (i_rst_n && i_cancel[0] && !o_abort[0])
        begin
            lag_cnt <= lag_cnt + 4'h1;
            if (lag_cnt == i_lag)
                o_abort <= 3'h1;
        end
    end
endmodule

// ---- can_mailbox_fifo_status_sva.sv ----
// Concurrent checks on the mailbox and receive queue status ports.
`timescale 1ns/1ps
`include "can_mbox_cfg.svh"
module can_mailbox_fifo_status_sva
    import can_mbox_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter rxq_count_t RXQ_DEPTH = `RXQ_DEPTH_DEFAULT
)
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [2:0] i_tx_request,
    input wire logic [2:0] i_tx_start,
    input wire logic [2:0] i_tx_success,
    input wire logic [2:0] i_tx_arb_lost,
    input wire logic [2:0] i_tx_error,
    input wire logic [2:0] i_tx_abort_done,
    input wire logic [2:0] o_mbox_empty,
    input wire logic [1:0] o_mbox_cancel,
    input wire logic [1:0] i_rxq_accept,
    input wire logic [1:0] o_rxq_release,
    input wire logic [1:0] o_rxq0_count,
    input wire logic [1:0] o_rxq1_count
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    property p_busy;
        i_tx_request[0] |=> !o_mbox_empty[0];
    endproperty
    a_busy: assert property (p_busy)
        else $error("mailbox 0 empty after request");
    property p_free;
        i_tx_success[1] && !i_tx_request[1] |=> o_mbox_empty[1];
    endproperty
    a_free: assert property (p_free)
        else $error("mailbox 1 busy after success");
    property p_arb;
        i_tx_arb_lost[0] ##1 (i_rd && i_addr == `TX_STATUS_OFS) |=> o_rdata[2];
    endproperty
    a_arb: assert property (p_arb)
        else $error("arbitration flag not read back");
    property p_rsvd;
        i_rd && i_addr == `TX_STATUS_OFS |=> o_rdata[6:4] == 3'h0 && o_rdata[14:12] == 3'h0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved status bits set");
    property p_cancel;
        o_mbox_empty[0] |-> !o_mbox_cancel[0];
    endproperty
    a_cancel: assert property (p_cancel)
        else $error("cancel held on a free mailbox");
    property p_pulse;
        o_rxq_release[0] |=> !o_rxq_release[0];
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("release pulse too long");
    property p_nonempty;
        o_rxq_release[1] |-> o_rxq1_count != 2'h0;
    endproperty
    a_nonempty: assert property (p_nonempty)
        else $error("release of an empty queue");
    property p_inc;
        i_rxq_accept[0] && o_rxq0_count != RXQ_DEPTH && !o_rxq_release[0]
            |=> o_rxq0_count == $past(o_rxq0_count) + 2'h1;
    endproperty
    a_inc: assert property (p_inc)
        else $error("queue 0 count missed an accept");
    property p_dec;
        o_rxq_release[0] && !i_rxq_accept[0] |=> o_rxq0_count == $past(o_rxq0_count) - 2'h1;
    endproperty
    a_dec: assert property (p_dec)
        else $error("queue 0 count missed a release");
    property p_keep;
        i_rxq_accept[1] && o_rxq1_count == RXQ_DEPTH && !o_rxq_release[1] |=> $stable(o_rxq1_count);
    endproperty
    a_keep: assert property (p_keep)
        else $error("queue 1 count moved while full");
    c_over: cover property (i_rxq_accept[0] && o_rxq0_count == RXQ_DEPTH);
    c_cancel: cover property (o_mbox_cancel[0]);
    c_rel: cover property (o_rxq_release[1]);
endmodule

bind can_mailbox_fifo_status can_mailbox_fifo_status_sva #(
    .ADDR_W(ADDR_W),
    .RXQ_DEPTH(RXQ_DEPTH)
) i_sva (.*);

// ---- can_mailbox_fifo_status_tb.sv ----
// Self-checking bench for the mailbox and receive queue status registers.
`timescale 1ns/1ps
`include "can_mbox_cfg.svh"
module can_mailbox_fifo_status_tb;
    import can_mbox_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic [31:0] o_rdata;
    logic [2:0] i_tx_request, i_tx_start, i_tx_success, i_tx_arb_lost, i_tx_error;
    logic [2:0] i_tx_abort_done, o_mbox_empty;
    logic [1:0] i_rxq_accept = 2'h0;
    logic [1:0] o_mbox_cancel, o_rxq_release, o_rxq0_count, o_rxq1_count;
    logic [2:0] m_op = 3'h0;
    logic [1:0] m_mb = 2'h0;
    logic [3:0] m_lag = 4'h0;
    logic [15:0] seed = 16'hF3A5;
    int mismatches = 0;
    int n_compared = 0;

    can_mailbox_fifo_status #(.ADDR_W(8), .RXQ_DEPTH(2'h3)) i_dut (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .i_tx_request(i_tx_request),
        .i_tx_start(i_tx_start),
        .i_tx_success(i_tx_success),
        .i_tx_arb_lost(i_tx_arb_lost),
        .i_tx_error(i_tx_error),
        .i_tx_abort_done(i_tx_abort_done),
        .o_mbox_empty(o_mbox_empty),
        .o_mbox_cancel(o_mbox_cancel),
        .i_rxq_accept(i_rxq_accept),
        .o_rxq_release(o_rxq_release),
        .o_rxq0_count(o_rxq0_count),
        .o_rxq1_count(o_rxq1_count)
    );
    can_tx_core_model i_core (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_op(m_op),
        .i_mb(m_mb),
        .i_lag(m_lag),
        .i_cancel(o_mbox_cancel),
        .o_req(i_tx_request),
        .o_start(i_tx_start),
        .o_ok(i_tx_success),
        .o_arb(i_tx_arb_lost),
        .o_err(i_tx_error),
        .o_abort(i_tx_abort_done)
    );

    always #12.5 i_core_clk = ~i_core_clk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [31:0] qword(input logic [1:0] c, input logic f, input logic o);
        return {26'h0, 1'b0, o, f, 1'b0, c};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 check(o_rdata, exp);
    endtask

    task automatic ev(input logic [2:0] code, input logic [1:0] mb);
        @(posedge i_core_clk);
        m_op <= code;
        m_mb <= mb;
        @(posedge i_core_clk);
        m_op <= 3'h0;
    endtask

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        #(25 * 4000);
        mismatches++;
        test_done;
    end

    initial
    begin
        logic [1:0] cnt;
        logic full;
        logic ovr;
        logic [7:0] ofs;
        repeat (3) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        check(32'(o_mbox_empty), 32'h0000_0007);
        rd(`TX_STATUS_OFS, 32'h1C00_0000);
        rd(8'h04, 32'h0000_0000);
        $display("test reset done");
        ev(3'h1, 2'h0);
        ev(3'h4, 2'h0);
        rd(`TX_STATUS_OFS, 32'h1800_0004);
        ev(3'h2, 2'h0);
        rd(`TX_STATUS_OFS, 32'h1800_0000);
        ev(3'h5, 2'h0);
        rd(`TX_STATUS_OFS, 32'h1800_0008);
        ev(3'h3, 2'h0);
        rd(`TX_STATUS_OFS, 32'h1C00_000B);
        // Software keeps the reserved bits at zero, so an all-zero write must change nothing.
        wr(`TX_STATUS_OFS, 32'h0000_0000);
        rd(`TX_STATUS_OFS, 32'h1C00_000B);
        wr(`TX_STATUS_OFS, 32'h0000_0001);
        rd(`TX_STATUS_OFS, 32'h1C00_0000);
        m_lag <= 4'h6;
        ev(3'h1, 2'h0);
        wr(`TX_STATUS_OFS, 32'h0000_0080);
        rd(`TX_STATUS_OFS, 32'h1800_0080);
        for (int k = 0; k < 40 && !o_mbox_empty[0]; k++)
            @(posedge i_core_clk);
        rd(`TX_STATUS_OFS, 32'h1C00_0001);
        wr(`TX_STATUS_OFS, 32'h0000_0080);
        rd(`TX_STATUS_OFS, 32'h1C00_0001);
        ev(3'h1, 2'h0);
        rd(`TX_STATUS_OFS, 32'h1800_0000);
        $display("test mailbox 0 done");
        ev(3'h1, 2'h1);
        ev(3'h4, 2'h1);
        rd(`TX_STATUS_OFS, 32'h1000_0400);
        ev(3'h3, 2'h1);
        rd(`TX_STATUS_OFS, 32'h1800_0700);
        wr(`TX_STATUS_OFS, 32'h0000_0100);
        rd(`TX_STATUS_OFS, 32'h1800_0000);
        ev(3'h1, 2'h2);
        rd(`TX_STATUS_OFS, 32'h0800_0000);
        ev(3'h3, 2'h2);
        rd(`TX_STATUS_OFS, 32'h1800_0000);
        $display("test mailbox 1 done");
        for (int q = 0; q < 2; q++)
        begin
            ofs = q ? `RXQ1_STATUS_OFS : `RXQ0_STATUS_OFS;
            cnt = 2'h0;
            full = 1'b0;
            ovr = 1'b0;
            wr(ofs, 32'h0000_0020);
            rd(ofs, 32'h0000_0000);
            for (int k = 0; k < 60; k++)
            begin
                seed = lfsr(seed);
                if (seed[0])
                begin
                    @(posedge i_core_clk);
                    i_rxq_accept <= 2'h1 << q;
                    @(posedge i_core_clk);
                    i_rxq_accept <= 2'h0;
                    if (cnt == 2'h3)
                        ovr = 1'b1;
                    else
                        cnt++;
                    full |= cnt == 2'h3;
                end
                else if (seed[1])
                begin
                    wr(ofs, 32'h0000_0020);
                    if (cnt != 2'h0)
                        cnt--;
                end
                else
                begin
                    wr(ofs, {seed, 10'h3FF, 6'h18});
                    // The full flag stays set while three messages still wait, since the set wins over the write-one clear.
                    full = cnt == 2'h3;
                    ovr = 1'b0;
                end
                rd(ofs, qword(cnt, full, ovr));
                check(32'(q ? o_rxq1_count : o_rxq0_count), 32'(cnt));
            end
            $display("test queue %0d done", q);
        end
        test_done;
    end
endmodule
